// ==== core/clock_unit.sv ====
/*
  clock unit: clock output select and external fast crystal monitor, with an
  avalon-mm register slave.
  assumes: one clock, asynchronous active-high reset; crystal activity arrives as a
  synchronous level that toggles while the crystal runs; software pins the alternate
  function of the output pin itself.
*/
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
// What this block does
// - decode four-bit select onto clock output
// - crystal failure turns crystal off
// - failure sets flag and fault event
// - crystal-fed system clock moves to rc
// - crystal-fed multiplier gets disabled
`timescale 1ns/10ps
`include "clock_unit_regs.svh"
module clock_unit
  import clock_unit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        crystal_activity,
  input  wire logic        system_clock,
  input  wire logic        internal_rc_clock,
  input  wire logic        fast_crystal_clock,
  input  wire logic        main_multiplier_clock,
  input  wire logic        second_multiplier_clock,
  input  wire logic        third_multiplier_clock,
  input  wire logic        external_clock_1,
  output logic             clock_output,
  output logic             crystal_enable,
  output logic             multiplier_enable,
  output logic [1:0]       system_clock_source,
  output logic             fault_event,
  output logic             irq
);
  // register fields, monitor and bus handshake state
  logic                 crystal_on;
  logic                 crystal_ready;
  logic                 monitor_enable;
  logic                 mult_on;
  logic                 mult_src;
  sys_src_e             sys_src;
  clock_sel_t           clock_out_select;
  logic [`INT_WIDTH-1:0] int_status;
  logic [`INT_WIDTH-1:0] int_mask;
  mon_state_e           mon_state;
  logic [7:0]           mon_count;
  logic                 activity_last;
  logic                 answered;
  logic                 ready_event;
  logic                 fail_event;

  logic                 next_crystal_on;
  logic                 next_crystal_ready;
  logic                 next_monitor_enable;
  logic                 next_mult_on;
  logic                 next_mult_src;
  sys_src_e             next_sys_src;
  clock_sel_t           next_clock_out_select;
  logic [`INT_WIDTH-1:0] next_int_status;
  logic [`INT_WIDTH-1:0] next_int_mask;
  mon_state_e           next_mon_state;
  logic [7:0]           next_mon_count;
  logic                 next_answered;
  logic [31:0]          next_readdata;
  logic                 next_fault_event;
  logic                 next_irq;

  logic wr_ctl;
  logic wr_cfg;
  logic wr_int;
  logic wr_mask;
  logic edge_seen;

  // ************************************************************
  // bus decode: one wait cycle, answer on the second edge
  // ************************************************************
  assign wr_ctl  = avs_write && !answered && avs_byteenable[0] && (avs_address == `CLOCK_CONTROL_REG_OFS);
  assign wr_cfg  = avs_write && !answered && avs_byteenable[0] && (avs_address == `CLOCK_CONFIG_REG_OFS);
  assign wr_int  = avs_write && !answered && avs_byteenable[0] && (avs_address == `CLOCK_INTERRUPT_REG_OFS);
  assign wr_mask = avs_write && !answered && avs_byteenable[0] && (avs_address == `CLOCK_MASK_REG_OFS);
  assign edge_seen = crystal_activity ^ activity_last;

  // ************************************************************
  // crystal monitor
  // ************************************************************
  // watch starts only once the crystal reports ready, so a slow start is no failure
  always_comb begin
    next_mon_state = mon_state;
    next_mon_count = mon_count;
    fail_event     = 1'b0;
    ready_event    = 1'b0;
    next_crystal_ready = crystal_ready;
    unique case (mon_state)
      mon_off: begin
        next_mon_count = 8'h00;
        next_crystal_ready = 1'b0;
        if (crystal_on) begin
          next_mon_state = mon_wait;
        end
      end
      mon_wait: begin
        next_mon_count = edge_seen ? mon_count + 8'h01 : mon_count;
        if (!crystal_on) begin
          next_mon_state = mon_off;
        end else if (mon_count >= `READY_DELAY_CYCLES) begin
          next_crystal_ready = 1'b1;
          ready_event    = 1'b1;
          next_mon_count = 8'h00;
          next_mon_state = mon_watch;
        end
      end
      mon_watch: begin
        next_mon_count = edge_seen ? 8'h00 : mon_count + 8'h01;
        if (!crystal_on) begin
          next_mon_state = mon_off;
        end else if (monitor_enable && mon_count >= `MONITOR_TIMEOUT_CYCLES) begin
          fail_event     = 1'b1;
          next_mon_state = mon_fail;
        end
      end
      mon_fail: begin
        // crystal already forced off; fall back to idle
        next_mon_state = mon_off;
      end
    endcase
  end

  // ************************************************************
  // register file next values
  // ************************************************************
  always_comb begin
    next_crystal_on       = wr_ctl ? avs_writedata[`CTL_CRYSTAL_ON_BIT] : crystal_on;
    next_monitor_enable   = wr_ctl ? avs_writedata[`CTL_MONITOR_ENABLE_BIT] : monitor_enable;
    next_mult_on          = wr_ctl ? avs_writedata[`CTL_MULT_ON_BIT] : mult_on;
    next_mult_src         = wr_ctl ? avs_writedata[`CTL_MULT_SRC_BIT] : mult_src;
    next_sys_src          = wr_cfg ? sys_src_e'(avs_writedata[`CFG_SYS_SRC_LSB +: 2]) : sys_src;
    next_clock_out_select = wr_cfg ? avs_writedata[`CFG_SEL_LSB +: 4] : clock_out_select;
    next_int_mask         = wr_mask ? avs_writedata[`INT_WIDTH-1:0] : int_mask;
    // write one clears; a same-cycle event wins
    next_int_status       = wr_int ? (int_status & ~avs_writedata[`INT_WIDTH-1:0]) : int_status;
    next_int_status[`INT_CRYSTAL_READY_BIT] = next_int_status[`INT_CRYSTAL_READY_BIT] | ready_event;
    next_fault_event = fail_event;
    if (fail_event) begin
      next_int_status[`INT_MONITOR_FAIL_BIT] = 1'b1;
      next_crystal_on = 1'b0;
      // real-time source selection is untouched here
      if (sys_src == sys_src_crystal || (sys_src == sys_src_mult && mult_src)) begin
        next_sys_src = sys_src_rc;
      end
      if (mult_src) begin
        next_mult_on = 1'b0;
      end
    end
    next_irq = |(next_int_status & next_int_mask);
  end

  // ************************************************************
  // read data and handshake
  // ************************************************************
  always_comb begin
    next_answered = (avs_read || avs_write) && !answered;
    next_readdata = 32'h0000_0000;
    if (avs_read && !answered) begin
      unique case (avs_address)
        `CLOCK_CONTROL_REG_OFS:   next_readdata = {27'h0, mult_src, mult_on, monitor_enable,
                                                    crystal_ready, crystal_on};
        `CLOCK_CONFIG_REG_OFS:    next_readdata = {24'h0, clock_out_select, 2'h0, sys_src};
        `CLOCK_INTERRUPT_REG_OFS: next_readdata = {30'h0, int_status};
        `CLOCK_MASK_REG_OFS:      next_readdata = {30'h0, int_mask};
        `CLOCK_STATUS_REG_OFS:    next_readdata = {30'h0, mon_state};
        default:                  next_readdata = 32'h0000_0000;  // unmapped reads zero
      endcase
    end else if (answered) begin
      next_readdata = avs_readdata;
    end
  end

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crystal_on        <= 1'(`CTL_RESET >> `CTL_CRYSTAL_ON_BIT);
      crystal_ready     <= 1'b0;
      monitor_enable    <= 1'b0;
      mult_on           <= 1'b0;
      mult_src          <= 1'b0;
      sys_src           <= sys_src_rc;
      clock_out_select  <= `SEL_RESET;
      int_status        <= '0;
      int_mask          <= '0;
      mon_state         <= mon_off;
      mon_count         <= 8'h00;
      activity_last     <= 1'b0;
      answered          <= 1'b0;
      avs_readdata      <= 32'h0000_0000;
      avs_waitrequest   <= 1'b1;
      crystal_enable    <= 1'b0;
      multiplier_enable <= 1'b0;
      system_clock_source <= 2'h0;
      fault_event       <= 1'b0;
      irq               <= 1'b0;
    end else begin
      crystal_on        <= next_crystal_on;
      crystal_ready     <= next_crystal_ready;
      monitor_enable    <= next_monitor_enable;
      mult_on           <= next_mult_on;
      mult_src          <= next_mult_src;
      sys_src           <= next_sys_src;
      clock_out_select  <= next_clock_out_select;
      int_status        <= next_int_status;
      int_mask          <= next_int_mask;
      mon_state         <= next_mon_state;
      mon_count         <= next_mon_count;
      activity_last     <= crystal_activity;
      answered          <= next_answered;
      avs_readdata      <= next_readdata;
      avs_waitrequest   <= !next_answered;
      crystal_enable    <= next_crystal_on;
      multiplier_enable <= next_mult_on;
      system_clock_source <= next_sys_src;
      fault_event       <= next_fault_event;
      irq               <= next_irq;
    end
  end

  // ************************************************************
  // clock output selection
  // ************************************************************
  clock_out_mux u_mux (
    .clk                     (clk),
    .reset                   (reset),
    .clock_out_select        (clock_out_select),
    .system_clock            (system_clock),
    .internal_rc_clock       (internal_rc_clock),
    .fast_crystal_clock      (fast_crystal_clock),
    .main_multiplier_clock   (main_multiplier_clock),
    .second_multiplier_clock (second_multiplier_clock),
    .third_multiplier_clock  (third_multiplier_clock),
    .external_clock_1        (external_clock_1),
    .clock_output            (clock_output)
  );
endmodule // clock_unit

// ==== core/clock_unit_regs.svh ====
/*
  register offsets, field positions, reset values and timing counts of the clock-output
  select and crystal monitor block.
  assumes: included by bare name; definitions only.
*/
`ifndef CLOCK_UNIT_REGS_SVH
`define CLOCK_UNIT_REGS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define CLOCK_CONTROL_REG_OFS   6'h00
`define CLOCK_CONFIG_REG_OFS    6'h04
`define CLOCK_INTERRUPT_REG_OFS 6'h08
`define CLOCK_MASK_REG_OFS      6'h0C
`define CLOCK_STATUS_REG_OFS    6'h10

// ************************************************************
// control register fields
// ************************************************************
`define CTL_CRYSTAL_ON_BIT      0
`define CTL_CRYSTAL_READY_BIT   1
`define CTL_MONITOR_ENABLE_BIT  2
`define CTL_MULT_ON_BIT         3
`define CTL_MULT_SRC_BIT        4
// ************************************************************
// config register fields
// ************************************************************
`define CFG_SYS_SRC_LSB         0
`define CFG_SEL_LSB             4
// ************************************************************
// interrupt / mask fields
// ************************************************************
`define INT_MONITOR_FAIL_BIT    0
`define INT_CRYSTAL_READY_BIT   1
`define INT_WIDTH               2

// ************************************************************
// reset values and timing
// ************************************************************
`define CTL_RESET               5'h00
`define SEL_RESET               4'h0
`define SYS_SRC_RESET           2'h0
// crystal must miss this many system clocks to count as failed
`define MONITOR_TIMEOUT_CYCLES  8'h40
`define READY_DELAY_CYCLES      8'h10
`endif

// ==== core/clock_unit_pkg.sv ====
/*
  types shared by the clock unit files.
  assumes: no surroundings; compiled first.
*/
package clock_unit_pkg;
  // system clock source codes
  typedef enum logic [1:0] {
    sys_src_rc       = 2'h0,
    sys_src_crystal  = 2'h1,
    sys_src_mult     = 2'h2
  } sys_src_e;

  // monitor state, gray along off -> wait -> watch
  typedef enum logic [1:0] {
    mon_off   = 2'h0,
    mon_wait  = 2'h1,
    mon_watch = 2'h3,
    mon_fail  = 2'h2
  } mon_state_e;

  typedef logic [3:0] clock_sel_t;
endpackage

// ==== core/clock_out_mux.sv ====
/*
  registered selection of one clock-domain source for the clock output pin.
  assumes: sources are sampled level signals in the clk domain; sel is stable.
*/
`timescale 1ns/10ps
`include "clock_unit_regs.svh"
module clock_out_mux
  import clock_unit_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire clock_sel_t clock_out_select,
  input  wire logic       system_clock,
  input  wire logic       internal_rc_clock,
  input  wire logic       fast_crystal_clock,
  input  wire logic       main_multiplier_clock,
  input  wire logic       second_multiplier_clock,
  input  wire logic       third_multiplier_clock,
  input  wire logic       external_clock_1,
  output logic            clock_output
);
  logic main_half;
  logic third_half;
  logic next_main_half;
  logic next_third_half;
  logic next_clock_output;

  // ************************************************************
  // halving dividers and selection
  // ************************************************************
  // toggle on each high sample; crude, but keeps one clock domain
  always_comb begin
    next_main_half  = main_half ^ main_multiplier_clock;
    next_third_half = third_half ^ third_multiplier_clock;
    unique casez (clock_out_select)
      4'b00??: next_clock_output = 1'b0;
      4'h4:    next_clock_output = system_clock;
      4'h5:    next_clock_output = internal_rc_clock;
      4'h6:    next_clock_output = fast_crystal_clock;
      4'h7:    next_clock_output = main_half;
      4'h8:    next_clock_output = second_multiplier_clock;
      4'h9:    next_clock_output = third_half;
      4'hA:    next_clock_output = external_clock_1;
      4'hB:    next_clock_output = third_multiplier_clock;
      default: next_clock_output = 1'b0;  // codes above 1011 reserved
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_half    <= 1'b0;
      third_half   <= 1'b0;
      clock_output <= 1'b0;
    end else begin
      main_half    <= next_main_half;
      third_half   <= next_third_half;
      clock_output <= next_clock_output;
    end
  end
endmodule // clock_out_mux

// ==== testbench/clock_unit_sva.sv ====
/*
  port checker for the clock unit: bus handshake, crystal failure reaction, idle pin.
  assumes: bound to clock_unit; one clock, asynchronous active-high reset.
*/
`timescale 1ns/10ps
`include "clock_unit_regs.svh"
module clock_unit_sva
  import clock_unit_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [5:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic       avs_waitrequest,
  input wire logic       clock_output,
  input wire logic       crystal_enable,
  input wire logic       multiplier_enable,
  input wire logic [1:0] system_clock_source,
  input wire logic       fault_event
);
  logic cfg_written;
  logic next_cfg_written;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ************************************************************
  // helper: first accepted config write; counted late so the pin check stays safe
  // ************************************************************
  always_comb begin
    next_cfg_written = cfg_written | (avs_write & ~avs_waitrequest & avs_byteenable[0]
                       & (avs_address == `CLOCK_CONFIG_REG_OFS));
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_written <= 1'b0;
    end else begin
      cfg_written <= next_cfg_written;
    end
  end
  sequence req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence crystal_lost;
    fault_event;
  endsequence
  wait_one_a: assert property (req_taken |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  no_spurious_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  fault_pulse_a: assert property (crystal_lost |=> !fault_event)
    else $error("fault event longer than one cycle");
  fault_xtal_off_a: assert property (crystal_lost |-> !crystal_enable && $past(crystal_enable))
    else $error("crystal not turned off on failure");
  fault_src_rc_a: assert property (crystal_lost and $past(system_clock_source) == sys_src_crystal
    |-> system_clock_source == sys_src_rc)
    else $error("system source not moved to rc");
  fault_mult_rc_a: assert property (crystal_lost and $past(system_clock_source) == sys_src_mult
    and $past(multiplier_enable) and !multiplier_enable |-> system_clock_source == sys_src_rc)
    else $error("dead multiplier left as system source");
  src_cause_a: assert property ($changed(system_clock_source) |-> fault_event || $past(avs_write))
    else $error("system source changed without cause");
  xtal_off_cause_a: assert property ($fell(crystal_enable) |-> fault_event || $past(avs_write))
    else $error("crystal dropped without cause");
  idle_pin_a: assert property (!cfg_written |-> !clock_output)
    else $error("clock output active before any selection");
endmodule // clock_unit_sva

bind clock_unit clock_unit_sva clock_unit_sva_inst (.clk(clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .clock_output(clock_output), .crystal_enable(crystal_enable),
  .multiplier_enable(multiplier_enable), .system_clock_source(system_clock_source),
  .fault_event(fault_event));

// ==== testbench/tb.sv ====
/*
  self-checking bench for the clock unit: select decode, reset values, crystal failure.
  assumes: sources are random levels; crystal activity toggles while the bench runs it.
*/
`timescale 1ns/10ps
`include "clock_unit_regs.svh"
module tb import clock_unit_pkg::*;;
  localparam logic [4:0] CTL_T [4] = '{5'h19, 5'h01, 5'h19, 5'h09};
  localparam logic [1:0] SRC_T [4] = '{2'h2, 2'h1, 2'h2, 2'h2};
  localparam logic [1:0] EXP_T [4] = '{2'h0, 2'h0, 2'h2, 2'h2};
  localparam logic       MON_T [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest;
  logic        crystal_activity = 1'b0;
  logic        run_xtal = 1'b0;
  logic [6:0]  src = 7'h00;
  logic [6:0]  prev_src = 7'h00;
  logic [1:0]  half = 2'h0;
  logic [1:0]  prev_half = 2'h0;
  logic        clock_output, crystal_enable, multiplier_enable, fault_event, irq;
  logic [1:0]  system_clock_source;
  int          bad_count = 0;
  int          tests_run = 0;
  int          n;
  int          seed;
  always #25 clk = ~clk;
  // random source levels; activity stops when the crystal is off or the bench kills it
  always @(posedge clk) begin
    src <= 7'($urandom);
    prev_src <= src;
    // bench copy of the halving toggles: bit 0 main, bit 1 third multiplier
    if (reset) begin
      half <= 2'h0;
    end else begin
      half <= half ^ {src[5], src[3]};
    end
    prev_half <= half;
    if (run_xtal && crystal_enable) crystal_activity <= ~crystal_activity;
  end
  clock_unit clock_unit_inst (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .crystal_activity(crystal_activity),
    .system_clock(src[0]), .internal_rc_clock(src[1]), .fast_crystal_clock(src[2]),
    .main_multiplier_clock(src[3]), .second_multiplier_clock(src[4]), .third_multiplier_clock(src[5]),
    .external_clock_1(src[6]), .clock_output(clock_output), .crystal_enable(crystal_enable),
    .multiplier_enable(multiplier_enable), .system_clock_source(system_clock_source),
    .fault_event(fault_event), .irq(irq));
  // ************************************************************
  // expectations and checks
  // ************************************************************
  function automatic logic exp_out(input logic [3:0] s, input logic [6:0] v, input logic [1:0] h);
    case (s)
      4'h4: return v[0];
      4'h5: return v[1];
      4'h6: return v[2];
      4'h7: return h[0];
      4'h8: return v[4];
      4'h9: return h[1];
      4'hA: return v[6];
      4'hB: return v[5];
      default: return 1'b0;
    endcase
  endfunction
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_pin(input string name, input logic [1:0] exp, input logic [1:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 40) begin
      bad_count++;
      close_out();
    end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = $urandom(22149);
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    tick();
    check_pin("clock_output", 2'h0, {1'b0, clock_output});
    bus(0, `CLOCK_CONFIG_REG_OFS, 32'h0, 4'hF);
    check_reg("config", 32'h0, rd);
    bus(0, 6'h14, 32'h0, 4'hF);
    check_reg("unmapped", 32'h0, rd);
    // lane 0 off: the write must be dropped, pin stays idle
    bus(1, `CLOCK_CONFIG_REG_OFS, 32'h40, 4'hE);
    bus(0, `CLOCK_CONFIG_REG_OFS, 32'h0, 4'hF);
    check_reg("config lane", 32'h0, rd);
    // every select code; the halving codes follow the bench's own toggle copy
    for (int s = 0; s < 16; s++) begin
      bus(1, `CLOCK_CONFIG_REG_OFS, {24'h0, 4'(s), 4'h0}, 4'hF); // pin mux is outside the block
      repeat (12) begin
        tick();
        check_pin("clock_output", {1'b0, exp_out(4'(s), prev_src, prev_half)}, {1'b0, clock_output});
      end
    end
    // crystal failure with several system sources and multiplier feeds
    for (int i = 0; i < 4; i++) begin
      bus(1, `CLOCK_MASK_REG_OFS, 32'h1, 4'hF);
      run_xtal <= 1'b1;
      bus(1, `CLOCK_CONTROL_REG_OFS, {27'h0, CTL_T[i]}, 4'hF);
      n = 0;
      do begin
        bus(0, `CLOCK_CONTROL_REG_OFS, 32'h0, 4'hF);
        n++;
      end while (rd[1] !== 1'b1 && n < 60);
      check_pin("crystal_ready", 2'h1, {1'b0, rd[1]});
      bus(1, `CLOCK_CONFIG_REG_OFS, {30'h0, SRC_T[i]}, 4'hF);
      bus(1, `CLOCK_CONTROL_REG_OFS, {27'h0, CTL_T[i] | {2'h0, MON_T[i], 2'h0}}, 4'hF);
      run_xtal <= 1'b0;
      n = 0;
      do begin
        tick();
        n++;
      end while (fault_event !== 1'b1 && n < 150);
      // real-time source is not modelled; software reselects it
      check_pin("fault_event", {1'b0, MON_T[i]}, {1'b0, fault_event});
      check_pin("crystal_enable", {1'b0, ~MON_T[i]}, {1'b0, crystal_enable});
      check_pin("multiplier_enable", {1'b0, ~EXP_T[i][1] ^ 1'b1}, {1'b0, multiplier_enable});
      check_pin("system_clock_source", EXP_T[i], system_clock_source);
      tick();
      check_pin("fault_event", 2'h0, {1'b0, fault_event});
      check_pin("irq", {1'b0, MON_T[i]}, {1'b0, irq});
      bus(0, `CLOCK_INTERRUPT_REG_OFS, 32'h0, 4'hF);
      check_reg("status", {30'h0, 1'b1, MON_T[i]}, rd);
      bus(0, `CLOCK_STATUS_REG_OFS, 32'h0, 4'hF);
      check_reg("monitor state", {30'h0, MON_T[i] ? mon_off : mon_watch}, rd);
      bus(1, `CLOCK_MASK_REG_OFS, 32'h0, 4'hF);
      tick();
      check_pin("irq masked", 2'h0, {1'b0, irq});
      bus(1, `CLOCK_MASK_REG_OFS, 32'h1, 4'hF);
      tick();
      check_pin("irq unmasked", {1'b0, MON_T[i]}, {1'b0, irq});
      bus(1, `CLOCK_INTERRUPT_REG_OFS, 32'h3, 4'hF);
      tick();
      check_pin("irq cleared", 2'h0, {1'b0, irq});
      bus(0, `CLOCK_INTERRUPT_REG_OFS, 32'h0, 4'hF);
      check_reg("status cleared", 32'h0, rd);
      bus(1, `CLOCK_CONTROL_REG_OFS, 32'h0, 4'hF);
    end
    close_out();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule // tb
